//--- rtl/csr_core_regs.sv
// The implementer's own choice: the APB register port.
module csr_core_regs
	import csr_pkg::*;
(
	// clock and reset
	input  wire logic                  CORE_CLK,
	input  wire logic                  RESETN,
	// register bus
	input  wire logic                  PSEL,
	input  wire logic                  PENABLE,
	input  wire logic                  PWRITE,
	input  wire logic [CSR_ADDR_W-1:0] PADDR,
	input  wire logic [31:0]           PWDATA,
	output logic      [31:0]           PRDATA,
	output logic                       PREADY,
	output logic                       PSLVERR,
	// execution port
	input  wire logic                  EXEC_VALID,
	input  csr_op_type                 EXEC_OP,
	input  wire logic [7:0]            EXEC_ARG_A,
	input  wire logic [7:0]            EXEC_ARG_B,
	input  wire logic [2:0]            WREG_SEL,
	// register views
	output logic      [7:0]            ACC_OUT,
	output logic      [7:0]            B_OUT,
	output logic      [7:0]            SP_OUT,
	output logic      [15:0]           DATA_PTR_PAIR_OUT,
	output logic      [7:0]            PSW_OUT,
	// internal RAM requests
	output logic                       RAM_WE,
	output logic      [7:0]            RAM_ADDR,
	output logic      [7:0]            RAM_WDATA,
	output logic      [7:0]            WREG_ADDR
);

	logic [7:0]  acc_reg;
	logic [7:0]  acc_next;
	logic [7:0]  b_reg;
	logic [7:0]  b_next;
	logic [7:0]  sp_reg;
	logic [7:0]  sp_next;
	logic [7:0]  dpl_reg;
	logic [7:0]  dph_reg;
	logic [15:0] data_ptr_pair_next;
	logic [7:0]  psw_reg;
	logic [7:0]  psw_next;
	logic        pready_reg;
	logic [31:0] prdata_reg;
	logic        pslverr_reg;
	logic        ram_we_reg;
	logic [7:0]  ram_addr_reg;
	logic [7:0]  ram_wdata_reg;
	logic [7:0]  wreg_addr_reg;

	logic        bit_space;
	logic [7:0]  tgt_idx;
	logic [2:0]  bit_sel;
	logic        map_ok;
	logic [7:0]  cur_byte;
	logic [7:0]  sw_val;
	logic [31:0] rd_val;
	logic        bus_setup;
	logic        wr_fire;
	logic        sw_acc;
	logic        sw_b;
	logic        sw_sp;
	logic        sw_dpl;
	logic        sw_dph;
	logic        sw_psw;

	logic [7:0]  alu_a;
	logic [7:0]  alu_b;
	logic [7:0]  alu_res_a;
	logic [7:0]  alu_res_b;
	logic        alu_wr_a;
	logic        alu_wr_b;
	logic        alu_cy;
	logic        alu_ac;
	logic        alu_ov;
	logic        alu_upd_cy;
	logic        alu_upd_ac;
	logic        alu_upd_ov;
	logic        hw_go;

	function automatic logic sfr_mapped(input logic [7:0] idx);
		return (idx == CSR_IDX_SP) || (idx == CSR_IDX_DPL) || (idx == CSR_IDX_DPH) ||
			(idx == CSR_IDX_PSW) || (idx == CSR_IDX_ACC) || (idx == CSR_IDX_B);
	endfunction

	function automatic logic bit_mappable(input logic [7:0] idx);
		return (idx == CSR_IDX_ACC) || (idx == CSR_IDX_B) || (idx == CSR_IDX_PSW);
	endfunction

	// ---- bus decode: byte space and bit space share one lookup
	assign bit_space = PADDR[CSR_BIT_SPACE_POS];
	assign bit_sel   = PADDR[4:2];
	assign tgt_idx   = bit_space ? {PADDR[9:5], 3'b000} : PADDR[9:2];
	assign map_ok    = (PADDR[1:0] == 2'b00) &&
		(bit_space ? bit_mappable(tgt_idx) : sfr_mapped(tgt_idx));
	assign bus_setup = PSEL && !PENABLE;
	assign wr_fire   = PSEL && PENABLE && pready_reg && PWRITE && map_ok;

	always_comb begin
		case (tgt_idx)
			CSR_IDX_SP:  cur_byte = sp_reg;
			CSR_IDX_DPL: cur_byte = dpl_reg;
			CSR_IDX_DPH: cur_byte = dph_reg;
			CSR_IDX_PSW: cur_byte = psw_reg;
			CSR_IDX_ACC: cur_byte = acc_reg;
			CSR_IDX_B:   cur_byte = b_reg;
			default:     cur_byte = 8'h00;
		endcase
	end

	always_comb begin
		sw_val = PWDATA[7:0];
		rd_val = {24'h000000, cur_byte};
		if (bit_space) begin
			// single-bit access: read-modify-write of the owning byte
			sw_val          = cur_byte;
			sw_val[bit_sel] = PWDATA[0];
			rd_val          = {31'h00000000, cur_byte[bit_sel]};
		end
	end

	assign sw_acc = wr_fire && (tgt_idx == CSR_IDX_ACC);
	assign sw_b   = wr_fire && (tgt_idx == CSR_IDX_B);
	assign sw_sp  = wr_fire && (tgt_idx == CSR_IDX_SP);
	assign sw_dpl = wr_fire && (tgt_idx == CSR_IDX_DPL);
	assign sw_dph = wr_fire && (tgt_idx == CSR_IDX_DPH);
	assign sw_psw = wr_fire && (tgt_idx == CSR_IDX_PSW);

	// ---- zero-wait-state bus answer, captured at the setup edge
	always_ff @(posedge CORE_CLK or negedge RESETN) begin
		if (!RESETN) begin
			pready_reg  <= 1'b0;
			prdata_reg  <= 32'h00000000;
			pslverr_reg <= 1'b0;
		end else begin
			pready_reg <= bus_setup;
			if (bus_setup) begin
				prdata_reg  <= (map_ok && !PWRITE) ? rd_val : 32'h00000000;
				pslverr_reg <= !map_ok;
			end
		end
	end

	// ---- flag and result unit
	assign hw_go = EXEC_VALID;
	assign alu_a = (EXEC_OP == CSR_OP_COMPARE_JUMP_OP) ? EXEC_ARG_A : acc_reg;
	assign alu_b = ((EXEC_OP == CSR_OP_MUL) || (EXEC_OP == CSR_OP_DIV)) ? b_reg : EXEC_ARG_B;

	csr_flag_alu u_alu (
		.op     (EXEC_OP),
		.a      (alu_a),
		.b      (alu_b),
		.cy_in  (psw_reg[CSR_PSW_CY]),
		.ac_in  (psw_reg[CSR_PSW_AC]),
		.res_a  (alu_res_a),
		.res_b  (alu_res_b),
		.wr_a   (alu_wr_a),
		.wr_b   (alu_wr_b),
		.cy_out (alu_cy),
		.ac_out (alu_ac),
		.ov_out (alu_ov),
		.upd_cy (alu_upd_cy),
		.upd_ac (alu_upd_ac),
		.upd_ov (alu_upd_ov)
	);

	// ---- next values: hardware results override a software write
	always_comb begin
		acc_next = acc_reg;
		if (sw_acc) begin
			acc_next = sw_val;
		end
		if (hw_go && alu_wr_a) begin
			acc_next = alu_res_a;
		end
	end

	always_comb begin
		b_next = b_reg;
		if (sw_b) begin
			b_next = sw_val;
		end
		if (hw_go && alu_wr_b) begin
			b_next = alu_res_b;
		end
	end

	always_comb begin
		sp_next = sp_reg;
		if (sw_sp) begin
			sp_next = sw_val;
		end
		if (hw_go && (EXEC_OP == CSR_OP_PUSH)) begin
			sp_next = sp_reg + 8'h01;
		end else if (hw_go && (EXEC_OP == CSR_OP_POP)) begin
			sp_next = sp_reg - 8'h01;
		end
	end

	always_comb begin
		data_ptr_pair_next = {dph_reg, dpl_reg};
		if (sw_dpl) begin
			data_ptr_pair_next[7:0] = sw_val;
		end
		if (sw_dph) begin
			data_ptr_pair_next[15:8] = sw_val;
		end
		if (hw_go && (EXEC_OP == CSR_OP_INC_DATA_PTR_PAIR)) begin
			data_ptr_pair_next = {dph_reg, dpl_reg} + 16'h0001;
		end
	end

	always_comb begin
		psw_next = psw_reg;
		if (sw_psw) begin
			// user flags and bank bits are plain storage; parity ignores writes
			psw_next[7:1] = sw_val[7:1];
		end
		if (hw_go && alu_upd_cy) begin
			psw_next[CSR_PSW_CY] = alu_cy;
		end
		if (hw_go && alu_upd_ac) begin
			psw_next[CSR_PSW_AC] = alu_ac;
		end
		if (hw_go && alu_upd_ov) begin
			psw_next[CSR_PSW_OV] = alu_ov;
		end
		psw_next[CSR_PSW_P] = ^acc_next;
	end

	// ---- register state
	always_ff @(posedge CORE_CLK or negedge RESETN) begin
		if (!RESETN) begin
			acc_reg <= CSR_RST_ACC;
			b_reg   <= CSR_RST_B;
		end else begin
			acc_reg <= acc_next;
			b_reg   <= b_next;
		end
	end

	always_ff @(posedge CORE_CLK or negedge RESETN) begin
		if (!RESETN) begin
			sp_reg <= CSR_RST_SP;
		end else begin
			sp_reg <= sp_next;
		end
	end

	always_ff @(posedge CORE_CLK or negedge RESETN) begin
		if (!RESETN) begin
			dpl_reg <= CSR_RST_DPL;
			dph_reg <= CSR_RST_DPH;
		end else begin
			dpl_reg <= data_ptr_pair_next[7:0];
			dph_reg <= data_ptr_pair_next[15:8];
		end
	end

	always_ff @(posedge CORE_CLK or negedge RESETN) begin
		if (!RESETN) begin
			psw_reg <= CSR_RST_PSW;
		end else begin
			psw_reg <= psw_next;
		end
	end

	// ---- stack store lands at the already incremented pointer
	always_ff @(posedge CORE_CLK or negedge RESETN) begin
		if (!RESETN) begin
			ram_we_reg    <= 1'b0;
			ram_addr_reg  <= 8'h00;
			ram_wdata_reg <= 8'h00;
		end else begin
			ram_we_reg <= hw_go && (EXEC_OP == CSR_OP_PUSH);
			if (hw_go && (EXEC_OP == CSR_OP_PUSH)) begin
				ram_addr_reg  <= sp_reg + 8'h01;
				ram_wdata_reg <= EXEC_ARG_B;
			end
		end
	end

	// ---- working register address: bank times eight plus register number
	always_ff @(posedge CORE_CLK or negedge RESETN) begin
		if (!RESETN) begin
			wreg_addr_reg <= 8'h00;
		end else begin
			wreg_addr_reg <= {3'b000, psw_reg[CSR_PSW_RS1:CSR_PSW_RS0], WREG_SEL};
		end
	end

	assign PRDATA    = prdata_reg;
	assign PREADY    = pready_reg;
	assign PSLVERR   = pslverr_reg;
	assign ACC_OUT   = acc_reg;
	assign B_OUT     = b_reg;
	assign SP_OUT    = sp_reg;
	assign DATA_PTR_PAIR_OUT  = {dph_reg, dpl_reg};
	assign PSW_OUT   = psw_reg;
	assign RAM_WE    = ram_we_reg;
	assign RAM_ADDR  = ram_addr_reg;
	assign RAM_WDATA = ram_wdata_reg;
	assign WREG_ADDR = wreg_addr_reg;

	// ---- checks
	logic add_cy_chk;
	logic compare_jump_op_lt_chk;
	logic push_go;

	assign add_cy_chk  = ({1'b0, acc_reg} + {1'b0, EXEC_ARG_B}) > 9'h0FF;
	assign compare_jump_op_lt_chk = EXEC_ARG_A < EXEC_ARG_B;
	assign push_go     = EXEC_VALID && (EXEC_OP == CSR_OP_PUSH);

	a_push_sp_inc: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
		push_go |=> (SP_OUT == $past(SP_OUT) + 8'h01))
		else $error("stack pointer did not advance on push");

	a_push_ram_slot: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
		push_go |=> (RAM_WE && (RAM_ADDR == SP_OUT) && (RAM_WDATA == $past(EXEC_ARG_B))))
		else $error("push wrote ram at wrong slot");

	a_parity_track: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
		PSW_OUT[CSR_PSW_P] == ^ACC_OUT)
		else $error("parity flag disagrees with operand register");

	a_add_carry_out: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
		(EXEC_VALID && (EXEC_OP == CSR_OP_ADD)) ##1 1'b1 |-> (PSW_OUT[CSR_PSW_CY] == $past(add_cy_chk)))
		else $error("carry wrong after add");

	a_mul_div_nocy: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
		(EXEC_VALID && ((EXEC_OP == CSR_OP_MUL) || (EXEC_OP == CSR_OP_DIV))) |=> !PSW_OUT[CSR_PSW_CY])
		else $error("carry set after product or quotient");

	a_div_zero_ov: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
		(EXEC_VALID && (EXEC_OP == CSR_OP_DIV) && (B_OUT == 8'h00))
		|=> (PSW_OUT[CSR_PSW_OV] && $stable(ACC_OUT) && $stable(B_OUT)))
		else $error("zero divisor not flagged");

	a_compare_jump_op_carry: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
		(EXEC_VALID && (EXEC_OP == CSR_OP_COMPARE_JUMP_OP)) |=> (PSW_OUT[CSR_PSW_CY] == $past(compare_jump_op_lt_chk)))
		else $error("compare carry wrong");

	a_bank_map: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
		##1 (WREG_ADDR == {3'b000, $past(PSW_OUT[4:3]), $past(WREG_SEL)}))
		else $error("working register address wrong");

	a_hw_flag_wins: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
		(sw_psw && EXEC_VALID && (EXEC_OP == CSR_OP_SETC)) |=> PSW_OUT[CSR_PSW_CY])
		else $error("software write beat hardware flag update");

	a_apb_answer: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
		(PSEL && !PENABLE && !PADDR[CSR_BIT_SPACE_POS] && (PADDR[1:0] != 2'b00)) |=> (PREADY && PSLVERR))
		else $error("misaligned access not refused");

endmodule

//--- rtl/csr_flag_alu.sv
module csr_flag_alu
	import csr_pkg::*;
(
	// operation and operands
	input  csr_op_type       op,
	input  wire logic [7:0]  a,
	input  wire logic [7:0]  b,
	input  wire logic        cy_in,
	input  wire logic        ac_in,
	// results and flags
	output logic [7:0]       res_a,
	output logic [7:0]       res_b,
	output logic             wr_a,
	output logic             wr_b,
	output logic             cy_out,
	output logic             ac_out,
	output logic             ov_out,
	output logic             upd_cy,
	output logic             upd_ac,
	output logic             upd_ov
);

	logic        cin;
	logic [8:0]  add9;
	logic [4:0]  add_lo5;
	logic [7:0]  add_lo8;
	logic [8:0]  sub9;
	logic [4:0]  sub_lo5;
	logic [7:0]  sub_lo8;
	logic [15:0] prod;
	logic [7:0]  div_by;
	logic        da_lo_fix;
	logic        da_hi_fix;
	logic [8:0]  da1;
	logic [8:0]  da2;

	assign cin     = (op == CSR_OP_ADDC) ? cy_in : 1'b0;
	assign add9    = {1'b0, a} + {1'b0, b} + {8'h00, cin};
	assign add_lo5 = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
	assign add_lo8 = {1'b0, a[6:0]} + {1'b0, b[6:0]} + {7'h00, cin};
	assign sub9    = {1'b0, a} - {1'b0, b} - {8'h00, cy_in};
	assign sub_lo5 = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, cy_in};
	assign sub_lo8 = {1'b0, a[6:0]} - {1'b0, b[6:0]} - {7'h00, cy_in};
	assign prod    = {8'h00, a} * {8'h00, b};
	// divisor forced nonzero so the divider never sees zero
	assign div_by  = (b == 8'h00) ? 8'h01 : b;

	assign da_lo_fix = (a[3:0] > CSR_BCD_MAX) | ac_in;
	assign da1       = {1'b0, a} + (da_lo_fix ? CSR_DA_ADJ_LO : 9'h000);
	assign da_hi_fix = (da1[7:4] > CSR_BCD_MAX) | da1[8] | cy_in;
	assign da2       = da1 + (da_hi_fix ? CSR_DA_ADJ_HI : 9'h000);

	always_comb begin
		res_a  = a;
		res_b  = b;
		wr_a   = 1'b0;
		wr_b   = 1'b0;
		cy_out = cy_in;
		ac_out = ac_in;
		ov_out = 1'b0;
		upd_cy = 1'b0;
		upd_ac = 1'b0;
		upd_ov = 1'b0;
		case (op)
			CSR_OP_ADD, CSR_OP_ADDC: begin
				res_a  = add9[7:0];
				wr_a   = 1'b1;
				cy_out = add9[8];
				ac_out = add_lo5[4];
				ov_out = add_lo8[7] ^ add9[8];
				upd_cy = 1'b1;
				upd_ac = 1'b1;
				upd_ov = 1'b1;
			end
			CSR_OP_SUBB: begin
				res_a  = sub9[7:0];
				wr_a   = 1'b1;
				cy_out = sub9[8];
				ac_out = sub_lo5[4];
				ov_out = sub_lo8[7] ^ sub9[8];
				upd_cy = 1'b1;
				upd_ac = 1'b1;
				upd_ov = 1'b1;
			end
			CSR_OP_MUL: begin
				res_a  = prod[7:0];
				res_b  = prod[15:8];
				wr_a   = 1'b1;
				wr_b   = 1'b1;
				cy_out = 1'b0;
				ov_out = prod > CSR_BYTE_MAX;
				upd_cy = 1'b1;
				upd_ov = 1'b1;
			end
			CSR_OP_DIV: begin
				// zero divisor: results are undefined, so both registers are left alone
				res_a  = a / div_by;
				res_b  = a % div_by;
				wr_a   = (b != 8'h00);
				wr_b   = (b != 8'h00);
				cy_out = 1'b0;
				ov_out = (b == 8'h00);
				upd_cy = 1'b1;
				upd_ov = 1'b1;
			end
			CSR_OP_DA: begin
				res_a  = da2[7:0];
				wr_a   = 1'b1;
				cy_out = da_hi_fix;
				upd_cy = 1'b1;
			end
			CSR_OP_COMPARE_JUMP_OP: begin
				cy_out = (a < b);
				upd_cy = 1'b1;
			end
			CSR_OP_SETC: begin
				cy_out = 1'b1;
				upd_cy = 1'b1;
			end
			CSR_OP_CLRC: begin
				cy_out = 1'b0;
				upd_cy = 1'b1;
			end
			default: begin
				res_a = a;
			end
		endcase
	end

endmodule

//--- rtl/csr_pkg.sv
package csr_pkg;

	// register bus geometry: byte space below, bit space above
	localparam int         CSR_ADDR_W        = 11;
	localparam int         CSR_BIT_SPACE_POS = 10;

	// register indices; byte address is four times the index
	localparam logic [7:0] CSR_IDX_SP  = 8'h81;
	localparam logic [7:0] CSR_IDX_DPL = 8'h82;
	localparam logic [7:0] CSR_IDX_DPH = 8'h83;
	localparam logic [7:0] CSR_IDX_PSW = 8'hD0;
	localparam logic [7:0] CSR_IDX_ACC = 8'hE0;
	localparam logic [7:0] CSR_IDX_B   = 8'hF0;

	// values after reset
	localparam logic [7:0] CSR_RST_SP  = 8'h07;
	localparam logic [7:0] CSR_RST_DPL = 8'h00;
	localparam logic [7:0] CSR_RST_DPH = 8'h00;
	localparam logic [7:0] CSR_RST_PSW = 8'h00;
	localparam logic [7:0] CSR_RST_ACC = 8'h00;
	localparam logic [7:0] CSR_RST_B   = 8'h00;

	// status word field positions
	localparam int CSR_PSW_CY  = 7;
	localparam int CSR_PSW_AC  = 6;
	localparam int CSR_PSW_F0  = 5;
	localparam int CSR_PSW_RS1 = 4;
	localparam int CSR_PSW_RS0 = 3;
	localparam int CSR_PSW_OV  = 2;
	localparam int CSR_PSW_F1  = 1;
	localparam int CSR_PSW_P   = 0;

	// decimal adjust constants and the product overflow limit
	localparam logic [3:0] CSR_BCD_MAX   = 4'h9;
	localparam logic [8:0] CSR_DA_ADJ_LO = 9'h006;
	localparam logic [8:0] CSR_DA_ADJ_HI = 9'h060;
	localparam logic [15:0] CSR_BYTE_MAX = 16'h00FF;

	typedef enum logic [3:0] {
		CSR_OP_NOP,
		CSR_OP_ADD,
		CSR_OP_ADDC,
		CSR_OP_SUBB,
		CSR_OP_MUL,
		CSR_OP_DIV,
		CSR_OP_DA,
		CSR_OP_COMPARE_JUMP_OP,
		CSR_OP_PUSH,
		CSR_OP_POP,
		CSR_OP_SETC,
		CSR_OP_CLRC,
		CSR_OP_INC_DATA_PTR_PAIR
	} csr_op_type;

endpackage

//--- test/csr_exec_model.sv
module csr_exec_model
	import csr_pkg::*;
(
	// clock
	input  wire logic       clk,
	// execution requests towards the register block
	output logic            exec_valid,
	output csr_op_type      exec_op,
	output logic [7:0]      arg_a,
	output logic [7:0]      arg_b,
	output logic [2:0]      wreg_sel
);
	timeunit 1ns;
	timeprecision 100ps;

	initial begin
		exec_valid = 1'b0;
		exec_op = CSR_OP_NOP;
		arg_a = 8'h00;
		arg_b = 8'h00;
		wreg_sel = 3'h0;
	end

	// one operation per edge; back to back calls keep valid high
	task automatic issue(input csr_op_type op, input logic [7:0] a, input logic [7:0] b);
		exec_valid <= 1'b1;
		exec_op <= op;
		arg_a <= a;
		arg_b <= b;
		@(posedge clk);
	endtask

	// idle operands change so a stale request is never taken for a new one
	task automatic stop();
		exec_valid <= 1'b0;
		exec_op <= CSR_OP_MUL;
		arg_a <= ~arg_a;
		arg_b <= ~arg_b;
		@(posedge clk);
	endtask

	task automatic pick_reg(input logic [2:0] r);
		wreg_sel <= r;
	endtask
endmodule

//--- test/testbench.sv
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin n_fail++; \
	$display("unexpected at %0t: got %h expected %h", $time, (g), (e)); end end

module testbench
	import csr_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;

	logic                  core_clk, resetn, psel, penable, pwrite, pready, pslverr, ram_we;
	logic [CSR_ADDR_W-1:0] paddr;
	logic [31:0]           pwdata, prdata;
	logic                  exec_valid;
	csr_op_type            exec_op;
	logic [7:0]            arg_a, arg_b, acc_out, b_out, sp_out, psw_out;
	logic [7:0]            ram_addr, ram_wdata, wreg_addr;
	logic [2:0]            wreg_sel, sel;
	logic [15:0]           data_ptr_pair_out, dp, r;
	logic [7:0]            acc, bb, sp, program_status_flags;
	logic [33:0]           apb_q[$];
	logic [15:0]           ram_q[$];
	logic [33:0]           e;
	int                    n_fail, total_checks, cyc;
	logic [7:0]            idx_list[7] = '{CSR_IDX_SP, CSR_IDX_DPL, CSR_IDX_DPH, CSR_IDX_PSW,
		CSR_IDX_ACC, CSR_IDX_B, 8'h84};
	csr_op_type            ops[6] = '{CSR_OP_ADD, CSR_OP_ADDC, CSR_OP_SUBB, CSR_OP_MUL,
		CSR_OP_DIV, CSR_OP_COMPARE_JUMP_OP};

	csr_core_regs DUT (.CORE_CLK(core_clk), .RESETN(resetn), .PSEL(psel), .PENABLE(penable),
		.PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
		.PSLVERR(pslverr), .EXEC_VALID(exec_valid), .EXEC_OP(exec_op), .EXEC_ARG_A(arg_a),
		.EXEC_ARG_B(arg_b), .WREG_SEL(wreg_sel), .ACC_OUT(acc_out), .B_OUT(b_out),
		.SP_OUT(sp_out), .DATA_PTR_PAIR_OUT(data_ptr_pair_out), .PSW_OUT(psw_out), .RAM_WE(ram_we),
		.RAM_ADDR(ram_addr), .RAM_WDATA(ram_wdata), .WREG_ADDR(wreg_addr));

	csr_exec_model u_exec (.clk(core_clk), .exec_valid(exec_valid), .exec_op(exec_op),
		.arg_a(arg_a), .arg_b(arg_b), .wreg_sel(wreg_sel));

	initial begin
		core_clk = 1'b0;
		forever #50 core_clk = ~core_clk;
	end

	function automatic logic mapped(input logic [7:0] i);
		return i inside {CSR_IDX_SP, CSR_IDX_DPL, CSR_IDX_DPH, CSR_IDX_PSW, CSR_IDX_ACC, CSR_IDX_B};
	endfunction

	function automatic logic [7:0] exp_of(input logic [7:0] i);
		case (i)
			CSR_IDX_SP: return sp;
			CSR_IDX_DPL: return dp[7:0];
			CSR_IDX_DPH: return dp[15:8];
			CSR_IDX_PSW: return {program_status_flags[7:1], ^acc};
			CSR_IDX_ACC: return acc;
			CSR_IDX_B: return bb;
			default: return 8'h00;
		endcase
	endfunction

	task automatic print_verdict();
		$display("checks %0d mismatches %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	// e = {write, error, read data}
	task automatic apb(input logic w, input logic [10:0] a, input logic [31:0] d,
		input logic [33:0] x);
		apb_q.push_back(x);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		@(posedge core_clk);
		while (pready !== 1'b1) @(posedge core_clk);
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge core_clk);
	endtask

	task automatic rd(input logic [7:0] i);
		apb(1'b0, {1'b0, i, 2'b00}, $urandom, {1'b0, ~mapped(i), 24'h0, exp_of(i)});
	endtask

	task automatic wr(input logic [7:0] i, input logic [7:0] v);
		apb(1'b1, {1'b0, i, 2'b00}, {24'($urandom), v}, {1'b1, ~mapped(i), 32'h0});
		case (i)
			CSR_IDX_SP: sp = v;
			CSR_IDX_DPL: dp[7:0] = v;
			CSR_IDX_DPH: dp[15:8] = v;
			CSR_IDX_PSW: program_status_flags[7:1] = v[7:1];
			CSR_IDX_ACC: acc = v;
			CSR_IDX_B: bb = v;
			default: ;
		endcase
	endtask

	task automatic bit_acc(input logic w, input logic [7:0] ba, input logic v, input logic x);
		apb(w, {1'b1, ba, 2'b00}, {31'h0, v}, {w, 1'b0, 31'h0, x});
	endtask

	// reference of the documented flag behaviour, then the request itself
	task automatic run(input csr_op_type op, input logic [7:0] x, input logic [7:0] y);
		logic [8:0]  s;
		logic [15:0] m;
		logic        c;
		c = program_status_flags[7] & (op != CSR_OP_ADD);
		case (op)
			CSR_OP_ADD, CSR_OP_ADDC: begin
				s = acc + y + c;
				program_status_flags[6] = (acc[3:0] + y[3:0] + c) > 15;
				program_status_flags[2] = s[8] ^ ((acc[6:0] + y[6:0] + c) > 127);
				program_status_flags[7] = s[8];
				acc = s[7:0];
			end
			CSR_OP_SUBB: begin
				s = {1'b0, acc} - y - c;
				program_status_flags[6] = acc[3:0] < {1'b0, y[3:0]} + c;
				program_status_flags[2] = (acc[7] ^ y[7]) & (acc[7] ^ s[7]);
				program_status_flags[7] = s[8];
				acc = s[7:0];
			end
			CSR_OP_MUL: begin
				m = acc * bb;
				program_status_flags[7] = 1'b0;
				program_status_flags[2] = m > 255;
				{bb, acc} = m;
			end
			CSR_OP_DIV: begin
				program_status_flags[7] = 1'b0;
				program_status_flags[2] = bb == 8'h00;
				if (bb != 8'h00) {acc, bb} = {acc / bb, acc % bb};
			end
			CSR_OP_DA: begin
				s = {1'b0, acc};
				if (acc[3:0] > 9 || program_status_flags[6]) s = s + 9'h006;
				if (s[7:4] > 9 || program_status_flags[7] || s[8]) begin
					s = s + 9'h060;
					program_status_flags[7] = 1'b1;
				end
				acc = s[7:0];
			end
			CSR_OP_COMPARE_JUMP_OP: program_status_flags[7] = x < y;
			CSR_OP_SETC: program_status_flags[7] = 1'b1;
			CSR_OP_CLRC: program_status_flags[7] = 1'b0;
			CSR_OP_PUSH: begin
				sp = sp + 8'h01;
				ram_q.push_back({sp, y});
			end
			CSR_OP_POP: sp = sp - 8'h01;
			CSR_OP_INC_DATA_PTR_PAIR: dp = dp + 16'h0001;
			default: ;
		endcase
		u_exec.issue(op, x, y);
	endtask

	always @(posedge core_clk) begin
		if (psel && penable && pready === 1'b1) begin
			e = apb_q.pop_front();
			`CHK(pslverr, e[32])
			if (!e[33]) `CHK(prdata, e[31:0])
		end
		if (ram_we === 1'b1) `CHK({ram_addr, ram_wdata}, ram_q.pop_front())
	end

	always @(posedge core_clk) begin
		cyc++;
		if (cyc == 30000) begin
			n_fail++;
			print_verdict();
		end
	end

	initial begin
		{resetn, psel, penable, pwrite, paddr, pwdata} = '0;
		{acc, bb, program_status_flags, dp} = '0;
		sp = 8'h07;
		void'($urandom(34781));
		repeat (12) @(posedge core_clk);
		resetn <= 1'b1;
		@(posedge core_clk);
		foreach (idx_list[i]) rd(idx_list[i]);
		apb(1'b0, 11'h206, 32'h0, {2'b01, 32'h0});
		$display("test reset_values done");
		run(CSR_OP_PUSH, 8'h00, 8'($urandom));
		run(CSR_OP_PUSH, 8'h00, 8'($urandom));
		run(CSR_OP_POP, 8'h00, 8'h00);
		u_exec.stop();
		rd(CSR_IDX_SP);
		$display("test stack done");
		foreach (idx_list[i]) begin
			wr(idx_list[i], 8'($urandom));
			rd(idx_list[i]);
		end
		wr(CSR_IDX_DPL, 8'hFF);
		wr(CSR_IDX_DPH, 8'h12);
		run(CSR_OP_INC_DATA_PTR_PAIR, 8'h00, 8'h00);
		u_exec.stop();
		`CHK(data_ptr_pair_out, 16'h1300)
		$display("test read_write done");
		for (int i = 0; i < 24; i++) begin
			wr(CSR_IDX_ACC, 8'($urandom));
			wr(CSR_IDX_B, (i == 4) ? 8'h00 : 8'($urandom));
			run(($urandom % 2) ? CSR_OP_SETC : CSR_OP_CLRC, 8'h00, 8'h00);
			run(ops[i % 6], 8'($urandom), 8'($urandom));
			u_exec.stop();
			`CHK(acc_out, acc)
			rd(CSR_IDX_B);
			rd(CSR_IDX_PSW);
		end
		wr(CSR_IDX_PSW, 8'h00);
		wr(CSR_IDX_ACC, 8'h9A);
		run(CSR_OP_DA, 8'h00, 8'h00);
		u_exec.stop();
		rd(CSR_IDX_ACC);
		rd(CSR_IDX_PSW);
		$display("test flags done");
		for (int n = 0; n < 4; n++) begin
			sel = 3'($urandom);
			u_exec.pick_reg(sel);
			wr(CSR_IDX_PSW, {3'b001, 2'(n), 3'b000});
			// bank address is registered one edge after the status write lands
			@(negedge core_clk);
			`CHK(wreg_addr, {3'b000, 2'(n), sel})
			`CHK(psw_out, {program_status_flags[7:1], ^acc})
		end
		$display("test banks done");
		bit_acc(1'b1, 8'hE3, 1'b1, 1'b0);
		acc[3] = 1'b1;
		bit_acc(1'b0, 8'hE3, 1'b0, 1'b1);
		bit_acc(1'b1, 8'hD0, ~(^acc), 1'b0);
		bit_acc(1'b0, 8'hD0, 1'b0, ^acc);
		bit_acc(1'b1, 8'hF7, 1'b1, 1'b0);
		bb[7] = 1'b1;
		rd(CSR_IDX_B);
		apb(1'b0, {1'b1, 8'h81, 2'b00}, 32'h0, {2'b01, 32'h0});
		$display("test bit_space done");
		fork
			wr(CSR_IDX_PSW, 8'h00);
			begin
				@(posedge core_clk);
				run(CSR_OP_SETC, 8'h00, 8'h00);
				u_exec.stop();
			end
		join
		program_status_flags[7] = 1'b1;
		rd(CSR_IDX_PSW);
		$display("test collision done");
		repeat (4) @(posedge core_clk);
		print_verdict();
	end
endmodule
